//--- logic/modem_irq_cfg.svh
`ifndef MODEM_IRQ_CFG_SVH
`define MODEM_IRQ_CFG_SVH
`define MCR_TERM_READY_BIT 0
`define MCR_USER_A_BIT     2
`define MCR_USER_B_BIT     3
`define MCR_LOOPBACK_BIT   4
`define MSR_DELTA_DSR_BIT  1
`define MSR_DSR_BIT        5
`define RX_OVERSAMPLE      16
`define RX_TICK_CNT_W      4
`endif

//--- logic/modem_irq_pkg.sv
package modem_irq_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic [1:0]
   {
      IRQ_NONE = 2'b00,
      IRQ_PEND = 2'b01
   } irq_state_t;
endpackage : modem_irq_pkg

//--- logic/modem_sync_if.sv
`timescale 1ns/1ps
interface modem_sync_if;
   logic level;
   logic change;
   modport src (output level, output change);
   modport dst (input level, input change);
endinterface : modem_sync_if

//--- logic/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
(
   // Clock and reset
   input  wire logic   clk_i,
   input  wire logic   reset_i,
   // Raw pin
   input  wire logic   pin_i,
   // Synchronised level and change pulse
   modem_sync_if.src   sync
);
   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
      logic stable;
      logic change;
   } sync_state_t;
   sync_state_t state_reg;
   sync_state_t state_next;

   always_comb
   begin
      state_next = state_reg;
      state_next.s1 = pin_i;
      state_next.s2 = state_reg.s1;
      state_next.s3 = state_reg.s2;
      state_next.change = 1'b0;
      // Accept a new level once second and third stages agree [R16]
      if ((state_reg.s2 == state_reg.s3) && (state_reg.s3 != state_reg.stable))
      begin
         state_next.stable = state_reg.s3;
         state_next.change = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (reset_i)
         state_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, stable: 1'b1, change: 1'b0};
      else
         state_reg <= state_next;
   end

   assign sync.level  = state_reg.stable;
   assign sync.change = state_reg.change;

   single_change_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R16]
      state_reg.change |=> !state_reg.change) else $error("change pulse too long");
endmodule : pin_sync

//--- logic/modem_signals_irq.sv
// Overview of operation
// R1: Status bit 5 shows present level of data-set-ready input.
// R2: Status bit 1 sets on any data-set-ready change; status read clears it.
// R3: Enabled modem status interrupt fires on data-set-ready change. The code suppresses it in loopback.
// R4: Terminal-ready output is active low, meaning ready to communicate.
// R5: Terminal-ready output active while its control bit is set.
// R6: Terminal-ready inactive after reset, in loopback, or with bit clear.
// R7: Interrupt output active high while any interrupt is pending.
// R8: Interrupt causes: receiver error, rx data/timeout, tx empty, modem status.
// R9: Interrupt drops when serviced or on master reset.
// R10: User outputs active low; control bit 2 drives a, bit 3 drives b.
// R11: User outputs forced high after reset, in loopback, or with bit clear.
// R12: Receiver timing comes from receiver clock at sixteen times baud.
// R13: Either read strobe polarity, with select, reads the addressed register.
// R14: Host uses one read strobe and ties the other inactive.
// R15: Active-high master reset clears registers and sets output levels.
// R16: Modem input is synchronised so one transition flags once.
`timescale 1ns/1ps
`include "modem_irq_cfg.svh"
module modem_signals_irq
#(
   parameter int RX_TICK_W = `RX_TICK_CNT_W
)
(
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 reset_i,
   // Modem side
   input  wire logic                 data_set_ready_n_i,
   input  wire logic                 rx_clock_i,
   output logic                      term_ready_n_o,
   output logic                      user_output_a_n_o,
   output logic                      user_output_b_n_o,
   // Host side
   input  wire logic                 chip_select_i,
   input  wire logic                 host_read_strobe_n_i,
   input  wire logic                 host_read_strobe_i,
   input  wire modem_irq_pkg::byte_t modem_control_reg_i,
   input  wire logic                 modem_irq_enable_i,
   input  wire logic                 rx_error_irq_i,
   input  wire logic                 rx_data_irq_i,
   input  wire logic                 tx_empty_irq_i,
   input  wire logic                 irq_serviced_i,
   output modem_irq_pkg::byte_t      modem_status_o,
   output logic                      read_active_o,
   output logic                      rx_sample_tick_o,
   output logic                      irq_o
);
   import modem_irq_pkg::*;

   modem_sync_if dsr_if();
   modem_sync_if rclk_if();

   typedef struct packed
   {
      byte_t            status;
      logic             delta_dsr;
      logic             term_n;
      logic             ua_n;
      logic             ub_n;
      logic             rd_prev;
      logic             rd_act;
      logic [RX_TICK_W-1:0] rx_cnt;
      logic             rx_tick;
      irq_state_t       irq_st;
      logic             modem_pend;
      logic             irq;
   } top_state_t;
   top_state_t state_reg;
   top_state_t state_next;

   logic read_now;
   logic read_start;
   logic loop_mode;

   pin_sync dsr_sync
   (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .pin_i   (data_set_ready_n_i),
      .sync    (dsr_if.src)
   );

   pin_sync rclk_sync
   (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .pin_i   (rx_clock_i),
      .sync    (rclk_if.src)
   );

   function automatic logic out_level_n(input byte_t modem_control_reg, input int bit_idx);
      // Active-low pin: low only when bit set and not in loopback
      out_level_n = !(modem_control_reg[bit_idx] && !modem_control_reg[`MCR_LOOPBACK_BIT]);
   endfunction : out_level_n

   always_comb
   begin
      // Either strobe polarity, gated by select [R13]
      read_now   = chip_select_i && (!host_read_strobe_n_i || host_read_strobe_i);
      read_start = read_now && !state_reg.rd_prev;
      loop_mode  = modem_control_reg_i[`MCR_LOOPBACK_BIT];
      state_next = state_reg;
      state_next.rd_prev = read_now;
      state_next.rd_act  = read_now;
      // Change flag: set wins over read clear [R2]
      if (dsr_if.change)
         state_next.delta_dsr = 1'b1;
      else if (read_start)
         state_next.delta_dsr = 1'b0;
      state_next.status = '0;
      state_next.status[`MSR_DSR_BIT]       = !dsr_if.level; // [R1]
      state_next.status[`MSR_DELTA_DSR_BIT] = state_next.delta_dsr; // [R2]
      state_next.term_n = out_level_n(modem_control_reg_i, `MCR_TERM_READY_BIT); // [R4] [R5] [R6]
      state_next.ua_n   = out_level_n(modem_control_reg_i, `MCR_USER_A_BIT); // [R10] [R11]
      state_next.ub_n   = out_level_n(modem_control_reg_i, `MCR_USER_B_BIT); // [R10] [R11]
      // Receiver tick on every sixteenth rising edge of receiver clock [R12]
      state_next.rx_tick = 1'b0;
      if (rclk_if.change && rclk_if.level)
      begin
         state_next.rx_cnt = state_reg.rx_cnt + RX_TICK_W'(1);
         if (state_reg.rx_cnt == RX_TICK_W'(`RX_OVERSAMPLE - 1))
            state_next.rx_tick = 1'b1;
      end
      // Modem status event pending while enabled and not in loopback; read or service clears it [R3] [R9]
      if (dsr_if.change && modem_irq_enable_i && !loop_mode)
         state_next.modem_pend = 1'b1;
      else if (read_start || irq_serviced_i)
         state_next.modem_pend = 1'b0;
      case (state_reg.irq_st)
         IRQ_NONE:
         begin
            if (rx_error_irq_i || rx_data_irq_i || tx_empty_irq_i || state_reg.modem_pend) // [R8]
               state_next.irq_st = IRQ_PEND;
         end
         IRQ_PEND:
         begin
            if (irq_serviced_i || !(rx_error_irq_i || rx_data_irq_i || tx_empty_irq_i
                || state_reg.modem_pend)) // [R9]
               state_next.irq_st = IRQ_NONE;
         end
         default:
            state_next.irq_st = IRQ_NONE;
      endcase
      state_next.irq = (state_next.irq_st == IRQ_PEND); // [R7]
   end

   always_ff @(posedge clk_i)
   begin
      // Master reset forces all outputs inactive [R15] [R6] [R11] [R9]
      if (reset_i)
         state_reg <= '{status: '0, delta_dsr: 1'b0, term_n: 1'b1, ua_n: 1'b1, ub_n: 1'b1,
                        rd_prev: 1'b0, rd_act: 1'b0, rx_cnt: '0, rx_tick: 1'b0,
                        irq_st: IRQ_NONE, modem_pend: 1'b0, irq: 1'b0};
      else
         state_reg <= state_next;
   end

   assign term_ready_n_o    = state_reg.term_n;
   assign user_output_a_n_o = state_reg.ua_n;
   assign user_output_b_n_o = state_reg.ub_n;
   assign modem_status_o    = state_reg.status;
   assign read_active_o     = state_reg.rd_act;
   assign rx_sample_tick_o  = state_reg.rx_tick;
   assign irq_o             = state_reg.irq;

   sequence dsr_moved;
      dsr_if.change;
   endsequence

   sequence modem_event;
      dsr_if.change && modem_irq_enable_i && !loop_mode && !irq_serviced_i;
   endsequence

   sequence read_begins;
      read_start && !dsr_if.change;
   endsequence

   delta_set_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R2]
      dsr_moved |=> modem_status_o[`MSR_DELTA_DSR_BIT])
      else $error("delta not set");
   read_clear_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R2]
      read_begins |=> !modem_status_o[`MSR_DELTA_DSR_BIT])
      else $error("delta not cleared by read");
   dsr_level_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R1]
      1'b1 |=> modem_status_o[`MSR_DSR_BIT] == !$past(dsr_if.level))
      else $error("dsr level");
   modem_irq_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R3]
      modem_event |-> ##[1:3] irq_o)
      else $error("no modem irq");
   term_ready_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R5]
      1'b1 |=> term_ready_n_o == !($past(modem_control_reg_i[`MCR_TERM_READY_BIT])
      && !$past(loop_mode))) else $error("term ready level");
   loop_quiet_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R6]
      loop_mode |=> term_ready_n_o && user_output_a_n_o && user_output_b_n_o)
      else $error("outputs active in loopback");
   user_a_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R10]
      !loop_mode && modem_control_reg_i[`MCR_USER_A_BIT] |=> !user_output_a_n_o)
      else $error("user a not active");
   user_b_on_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R10]
      !loop_mode && modem_control_reg_i[`MCR_USER_B_BIT] |=> !user_output_b_n_o)
      else $error("user b not active");
   user_a_off_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R11]
      !modem_control_reg_i[`MCR_USER_A_BIT] |=> user_output_a_n_o)
      else $error("user a not high");
   user_b_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R11]
      !modem_control_reg_i[`MCR_USER_B_BIT] |=> user_output_b_n_o)
      else $error("user b not high");
   irq_cause_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R8]
      $rose(irq_o) |-> $past(rx_error_irq_i || rx_data_irq_i || tx_empty_irq_i
      || state_reg.modem_pend)) else $error("irq without cause");
   irq_clear_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R9]
      irq_o && irq_serviced_i |=> !irq_o)
      else $error("irq not cleared");
   rx_tick_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R12]
      rx_sample_tick_o |-> $past(rclk_if.change && rclk_if.level))
      else $error("tick without receiver clock edge");
   read_strobe_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R13]
      chip_select_i && host_read_strobe_i |=> read_active_o)
      else $error("read ignored");
   read_low_a : assert property (@(posedge clk_i) disable iff (reset_i) // [R13]
      chip_select_i && !host_read_strobe_n_i |=> read_active_o)
      else $error("low read ignored");
   reset_out_a : assert property (@(posedge clk_i) // [R15]
      reset_i |=> term_ready_n_o && !irq_o && user_output_a_n_o)
      else $error("reset levels");
endmodule : modem_signals_irq

//--- bench/modem_model.sv
`timescale 1ns/1ps
module modem_model
(
   // Modem pins toward the device
   output logic dsr_n_o,
   output logic rx_clock_o
);
   initial
   begin
      dsr_n_o    = 1'b1;
      rx_clock_o = 1'b0;
   end
   // Pin level change, off the device clock edges
   task automatic set_ready(input logic ready);
      #3 dsr_n_o = ~ready;
   endtask : set_ready
   // Receiver clock burst, idle low between bursts
   task automatic rx_burst(input int edges);
      repeat (edges)
      begin
         #37 rx_clock_o = 1'b1;
         #37 rx_clock_o = 1'b0;
      end
   endtask : rx_burst
endmodule : modem_model

//--- bench/uart_modem_signals_and_irq_tb.sv
`timescale 1ns/1ps
module uart_modem_signals_and_irq_tb;
   import modem_irq_pkg::*;
   logic  clk_i = 1'b0, reset_i = 1'b1, cs = 1'b0, rd_n = 1'b1, rd = 1'b0;
   logic  en = 1'b0, rxe = 1'b0, rxd = 1'b0, txe = 1'b0, svc = 1'b0;
   logic  dsr_n, rxc, dtr_n, ua_n, ub_n, rd_act, tick, irq;
   byte_t modem_control_reg = 8'h00, msr, exp_v;
   byte_t mcr_tab[5] = '{8'h01, 8'h04, 8'h08, 8'h1d, 8'h00};
   logic  [2:0] causes;
   int    n_errors = 0, cmp_count = 0, cycles = 0, ticks = 0;
   modem_model model (.dsr_n_o(dsr_n), .rx_clock_o(rxc));
   modem_signals_irq dut
   (
      .clk_i(clk_i), .reset_i(reset_i), .data_set_ready_n_i(dsr_n), .rx_clock_i(rxc),
      .term_ready_n_o(dtr_n), .user_output_a_n_o(ua_n), .user_output_b_n_o(ub_n),
      .chip_select_i(cs), .host_read_strobe_n_i(rd_n), .host_read_strobe_i(rd),
      .modem_control_reg_i(modem_control_reg), .modem_irq_enable_i(en), .rx_error_irq_i(rxe),
      .rx_data_irq_i(rxd), .tx_empty_irq_i(txe), .irq_serviced_i(svc),
      .modem_status_o(msr), .read_active_o(rd_act), .rx_sample_tick_o(tick), .irq_o(irq)
   );
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      cycles++;
      if (tick === 1'b1) ticks++;
      if (cycles == 5000)
      begin
         n_errors++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   task automatic chk(input string what, input byte_t exp, input byte_t got);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : step
   task automatic service();
      @(posedge clk_i) svc <= 1'b1;
      @(posedge clk_i) svc <= 1'b0;
   endtask : service
   // Qualified read with one strobe, the other held inactive
   task automatic host_read(input logic high_strobe);
      @(posedge clk_i);
      cs <= 1'b1;
      if (high_strobe) rd <= 1'b1;
      else rd_n <= 1'b0;
      step(2);
      chk("read_active", 8'h01, byte_t'(rd_act));
      @(posedge clk_i);
      cs   <= 1'b0;
      rd   <= 1'b0;
      rd_n <= 1'b1;
   endtask : host_read
   initial
   begin
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      step(1);
      chk("term_ready", 8'h01, byte_t'(dtr_n));
      chk("user_a", 8'h01, byte_t'(ua_n));
      chk("user_b", 8'h01, byte_t'(ub_n));
      chk("irq", 8'h00, byte_t'(irq));
      chk("status", 8'h00, msr);
      $display("test reset done");
      foreach (mcr_tab[i])
      begin
         @(posedge clk_i) modem_control_reg <= mcr_tab[i];
         step(2);
         exp_v = mcr_tab[i];
         chk("term_ready", byte_t'(!(exp_v[0] && !exp_v[4])), byte_t'(dtr_n));
         chk("user_a", byte_t'(!(exp_v[2] && !exp_v[4])), byte_t'(ua_n));
         chk("user_b", byte_t'(!(exp_v[3] && !exp_v[4])), byte_t'(ub_n));
      end
      $display("test control outputs done");
      @(posedge clk_i) en <= 1'b1;
      model.set_ready(1'b1);
      step(8);
      chk("status", 8'h22, msr);
      chk("irq", 8'h01, byte_t'(irq));
      service();
      step(2);
      chk("irq", 8'h00, byte_t'(irq));
      host_read(1'b0);
      step(3);
      chk("status", 8'h20, msr);
      @(posedge clk_i) en <= 1'b0;
      model.set_ready(1'b0);
      step(8);
      chk("status", 8'h02, msr);
      chk("irq", 8'h00, byte_t'(irq));
      host_read(1'b1);
      step(3);
      chk("status", 8'h00, msr);
      $display("test modem status done");
      @(posedge clk_i) {en, modem_control_reg} <= {1'b1, 8'h10};
      model.set_ready(1'b1);
      step(8);
      chk("irq", 8'h00, byte_t'(irq));
      chk("status", 8'h22, msr);
      host_read(1'b0);
      @(posedge clk_i) {en, modem_control_reg} <= {1'b0, 8'h00};
      step(2);
      chk("status", 8'h20, msr);
      $display("test loopback done");
      for (int i = 0; i < 3; i++)
      begin
         causes = 3'b001 << i;
         @(posedge clk_i) {txe, rxd, rxe} <= causes;
         step(3);
         chk("irq", 8'h01, byte_t'(irq));
         @(posedge clk_i) {txe, rxd, rxe} <= 3'b000;
         service();
         step(3);
         chk("irq", 8'h00, byte_t'(irq));
      end
      $display("test irq causes done");
      ticks = 0;
      model.rx_burst(32);
      step(8);
      chk("rx_ticks", 8'h02, byte_t'(ticks));
      $display("test rx clock done");
      stop_test();
   end
endmodule : uart_modem_signals_and_irq_tb
